// *** bench/ddrosc_mem_model.sv ***
// Behavioural memory side: drives the data strobe for read bursts.
// Assumes the strobe line is terminated high while nobody drives it.
`timescale 1ns/1ps
`default_nettype none
module ddrosc_mem_model #(
    parameter realtime HALF_NS = 62.5,
    parameter int BURSTS = 4,
    parameter bit TERM_LEVEL = 1'b1
) (
    input wire logic start, // Rising edge begins one read burst.
    input wire logic slow, // High: preamble held longer.
    output logic strobe // Strobe level at the pin.
);
    initial
    begin
        strobe = TERM_LEVEL;
        forever
        begin
            @(posedge start);
            strobe = 1'b0;
            // A slow answer shifts the first rise by a whole, odd number of core cycles.
            // The extra tenth of a half period keeps every strobe edge clear of the
            // core clock's edges, since the edges then step by a quarter core cycle.
            #(HALF_NS * (slow ? 6.1 : 2.1));
            repeat (BURSTS)
            begin
                strobe = 1'b1;
                #(HALF_NS);
                strobe = 1'b0;
                #(HALF_NS);
            end
            strobe = TERM_LEVEL;
        end
    end
endmodule : ddrosc_mem_model
`default_nettype wire

// *** bench/ddrosc_top_tb.sv ***
// Self-checking bench for the double-rate output path and strobe control.
// Assumes the memory model drives the strobe pin; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module ddrosc_top_tb;
    import ddrosc_pkg::*;
    logic core_clk, rst, sdr_latch, out_enable, word_valid, word_ready, pad_oe, read_en;
    logic [1:0] mode;
    logic [DATA_LANES-1:0] first_data_in, second_data_in, pad_out;
    logic [CAL_W-1:0] dll_cal;
    logic strobe_in, read_strobe_shifted, write_strobe_shifted, sync_clock_polarity;
    logic read_word_valid, sys_clk_level, mem_start, mem_slow, pol_a, pol_b;
    int err_count, num_checks, rd_a, wr_a, rd_b, wr_b;
    int tick = 0;
    int cyc = 0;
    logic [7:0] smp [40];

    ddrosc_top dut (.core_clk(core_clk), .rst(rst), .mode(mode), .sdr_latch(sdr_latch),
        .out_enable(out_enable), .word_valid(word_valid), .word_ready(word_ready),
        .first_data_in(first_data_in), .second_data_in(second_data_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .strobe_in(strobe_in), .read_en(read_en), .dll_cal(dll_cal),
        .read_strobe_shifted(read_strobe_shifted), .write_strobe_shifted(write_strobe_shifted),
        .sync_clock_polarity(sync_clock_polarity), .read_word_valid(read_word_valid),
        .sys_clk_level(sys_clk_level));

    ddrosc_mem_model mem (.start(mem_start), .slow(mem_slow), .strobe(strobe_in));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // The ceiling is several times the expected run length.
    always @(posedge core_clk)
    begin
        tick <= tick + 1;
        cyc <= rst ? 0 : cyc + 1;
        if (tick == 5000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Fills the buffer with the drain stalled, then drains and checks the pad sequence.
    task automatic stream_case(input logic [1:0] md);
        int acc;
        int at;
        logic [7:0] want;
        @(negedge core_clk);
        mode = md;
        acc = 0;
        for (int k = 0; k < 10; k++)
        begin
            @(negedge core_clk);
            if (word_ready !== 1'b1)
                break;
            word_valid = 1'b1;
            first_data_in = 8'ha0 + 8'(k);
            second_data_in = 8'h50 + 8'(k);
            acc++;
        end
        word_valid = 1'b0;
        check(16'(acc), 16'(FIFO_DEPTH));
        out_enable = 1'b1;
        for (int j = 0; j < 40; j++)
        begin
            @(negedge core_clk);
            smp[j] = pad_out;
        end
        check(16'(pad_oe), 16'h0001);
        at = -1;
        for (int j = 0; j < 24; j++)
            if (at < 0 && smp[j] === 8'ha0)
                at = j;
        check(16'(at >= 0), 16'h0001);
        // Generic mode alternates both bits; the other modes show the first bit twice.
        if (at >= 0)
            for (int j = 0; j < 16; j++)
            begin
                want = (md == MODE_GDDR && j % 2 == 1) ? 8'h50 + 8'(j / 2) : 8'ha0 + 8'(j / 2);
                check(16'(smp[at + j]), 16'(want));
            end
        out_enable = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask : stream_case

    task automatic latch_case();
        @(negedge core_clk);
        mode = MODE_SDR;
        sdr_latch = 1'b1;
        out_enable = 1'b1;
        word_valid = 1'b1;
        first_data_in = 8'h3c;
        second_data_in = 8'hc3;
        @(negedge core_clk);
        word_valid = 1'b0;
        repeat (6) @(negedge core_clk);
        check(16'(pad_out), 16'h003c);
        sdr_latch = 1'b0;
        repeat (6) @(negedge core_clk);
        out_enable = 1'b0;
    endtask : latch_case

    // One read burst; delays are counted from the first strobe rise seen at the pin.
    task automatic read_case(input logic slow, input logic [CAL_W-1:0] dll, output logic pol,
        output int rd, output int wr);
        int pin_t;
        int pulses;
        logic p_pin, p_rd, p_wr;
        @(negedge core_clk);
        while (cyc % 2 != 0)
            @(negedge core_clk);
        check(16'(sys_clk_level), 16'(cyc % 2));
        mode = MODE_MDDR;
        dll_cal = dll;
        read_en = 1'b1;
        mem_slow = slow;
        mem_start = 1'b1;
        pin_t = -1;
        rd = -1;
        wr = -1;
        pulses = 0;
        p_pin = strobe_in;
        p_rd = read_strobe_shifted;
        p_wr = write_strobe_shifted;
        for (int k = 0; k < 110; k++)
        begin
            @(negedge core_clk);
            if (strobe_in === 1'b1 && p_pin === 1'b0 && pin_t < 0)
                pin_t = k;
            if (read_strobe_shifted === 1'b1 && p_rd === 1'b0 && rd < 0)
                rd = k;
            if (write_strobe_shifted === 1'b1 && p_wr === 1'b0 && wr < 0)
                wr = k;
            if (read_word_valid === 1'b1)
                pulses++;
            p_pin = strobe_in;
            p_rd = read_strobe_shifted;
            p_wr = write_strobe_shifted;
        end
        pol = sync_clock_polarity;
        rd = rd - pin_t;
        wr = wr - pin_t;
        check(16'(pulses), 16'h0004);
        read_en = 1'b0;
        mem_start = 1'b0;
        repeat (10) @(negedge core_clk);
    endtask : read_case

    initial
    begin
        rst = 1'b1;
        mode = MODE_GDDR;
        sdr_latch = 1'b0;
        out_enable = 1'b0;
        word_valid = 1'b0;
        first_data_in = 8'h00;
        second_data_in = 8'h00;
        read_en = 1'b0;
        dll_cal = 6'h00;
        mem_start = 1'b0;
        mem_slow = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        check(16'({pad_out, pad_oe, word_ready, read_word_valid, sync_clock_polarity}), 16'h0004);
        rst = 1'b0;
        stream_case(MODE_GDDR);
        stream_case(MODE_SDR);
        stream_case(MODE_MDDR);
        latch_case();
        read_case(1'b0, 6'h02, pol_a, rd_a, wr_a);
        read_case(1'b1, 6'h05, pol_b, rd_b, wr_b);
        // The slow burst moves the first rise by an odd number of cycles.
        check(16'(pol_b), 16'(!pol_a));
        check(16'(rd_b - rd_a), 16'h0003);
        check(16'(wr_b - wr_a), 16'h0001);
        check(16'(rd_a >= 4 && rd_a <= 8), 16'h0001);
        check(16'(wr_a >= 3 && wr_a <= 7), 16'h0001);
        print_verdict();
    end
endmodule : ddrosc_top_tb
`default_nettype wire

// *** rtl/ddrosc_fifo.sv ***
// Output data buffer between the core and the double-rate register path.
// Assumes both sides share the core clock; ready on the fill side is a flop.
`timescale 1ns/1ps
`default_nettype none
module ddrosc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic core_clk, // Core clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic in_valid, // Word offered by the source.
    output logic in_ready, // Space available.
    input wire logic [WIDTH-1:0] in_data, // Offered word.
    output logic out_valid, // Word available to the drain.
    input wire logic out_ready, // Drain takes the head word.
    output logic [WIDTH-1:0] out_data // Head word.
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic not_full;
    } ddrosc_fifo_st_t;

    ddrosc_fifo_st_t st;
    ddrosc_fifo_st_t next_st;
    logic push;
    logic pop;

    assign push = in_valid && st.not_full;
    assign pop = out_ready && (st.count != '0);
    assign in_ready = st.not_full;
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rptr];

    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop)
        begin
            next_st.rptr = st.rptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_st.count = st.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_st.count = st.count - 1'b1;
        end
        next_st.not_full = (next_st.count != FULL_COUNT);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.not_full <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_fifo_no_overrun: assert property (st.count == FULL_COUNT |-> !in_ready)
        else $error("Buffer offers space while full.");
    a_fifo_count_step: assert property ((push && !pop) |=> st.count == $past(st.count) + 1'b1)
        else $error("Buffer count did not follow a push.");
endmodule : ddrosc_fifo
`default_nettype wire

// *** rtl/ddrosc_pkg.sv ***
// Package for the double-rate output and strobe control block.
// Assumes a single 100 MHz core clock; all slower rates are enables.
package ddrosc_pkg;
    // Clock period of the core clock in nanoseconds.
    localparam int CORE_CLK_PERIOD_NS = 10;
    // Data lanes served by one strobe group; two such groups make a 16-bit path.
    localparam int DATA_LANES = 8; // RULE_07
    // Width of the delay calibration bus.
    localparam int CAL_W = 6;
    // Depth of the output data buffer in words.
    localparam int FIFO_DEPTH = 8;
    // One buffer word holds both bits of every lane.
    localparam int WORD_W = 2 * DATA_LANES;
    // Bit position of the first bits inside a buffer word.
    localparam int FIRST_LSB = 0;
    // Bit position of the second bits inside a buffer word.
    localparam int SECOND_LSB = DATA_LANES;
    // Output modes.
    localparam logic [1:0] MODE_SDR = 2'h0;
    localparam logic [1:0] MODE_GDDR = 2'h1;
    localparam logic [1:0] MODE_MDDR = 2'h2;
    // The write strobe is delayed by half the calibrated read delay.
    localparam int WR_DELAY_SHIFT = 1;
    // Reset values.
    localparam logic [DATA_LANES-1:0] DATA_RESET = 8'h00;
    localparam logic [CAL_W-1:0] CNT_RESET = 6'h00;
    // Level of the strobe pin while nobody drives it, held by termination.
    localparam logic STROBE_IDLE = 1'h1;

    typedef enum logic [2:0]
    {
        RD_IDLE = 3'b001,
        RD_PRE = 3'b010,
        RD_ACT = 3'b100
    } ddrosc_rd_state_t;
endpackage : ddrosc_pkg

// *** rtl/ddrosc_top.sv ***
// Double-rate output register path and strobe read/write control for one group.
// Assumes the core supplies two bits per lane per system-clock period through
// a buffer, and that the strobe pin arrives asynchronously to core_clk.
// Functional notes
// [RULE_01] Single-rate mode passes the first bit through one register or latch.
// [RULE_02] Generic double-rate captures both bits on rise, second moves to fall register.
// [RULE_03] Generic double-rate mux is switched by the system clock.
// [RULE_04] Right-edge block adds memory double-rate mode to single and generic modes.
// [RULE_05] Memory double-rate captures both bits on rise, second moves on next fall.
// [RULE_06] Memory double-rate mux is switched by the shifted write strobe.
// [RULE_07] Groups of 14 or 12 cells give memory paths up to 16 bits.
// [RULE_08] One control element per group drives phase clocks, polarity and valid.
// [RULE_09] Read and write shifted clocks are derived from the incoming strobe.
// [RULE_10] Polarity selector picks the system edge for read synchronising registers.
// [RULE_11] Polarity is re-evaluated at the start of every read cycle.
// [RULE_12] First rising strobe after preamble sets the polarity signal.
// [RULE_13] Memory leaves strobe undriven, then drives it low for the preamble.
// [RULE_14] Strobe delay takes a 6-bit calibration bus from the edge DLL.
// [RULE_15] Select high drives the rise register, select low the fall register.
`timescale 1ns/1ps
`default_nettype none
module ddrosc_top #(
    parameter bit RIGHT_EDGE = 1'b1
) (
    input wire logic core_clk, // Core clock, 100 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [1:0] mode, // Output mode select.
    input wire logic sdr_latch, // Single-rate element acts as a latch.
    input wire logic out_enable, // Core asks to drive the data pads.
    input wire logic word_valid, // Core offers a word.
    output logic word_ready, // Buffer accepts the word.
    input wire logic [ddrosc_pkg::DATA_LANES-1:0] first_data_in, // Bits for the high half.
    input wire logic [ddrosc_pkg::DATA_LANES-1:0] second_data_in, // Bits for the low half.
    output logic [ddrosc_pkg::DATA_LANES-1:0] pad_out, // Data pad output.
    output logic pad_oe, // Data pad output enable.
    input wire logic strobe_in, // Strobe pin level from the memory.
    input wire logic read_en, // Core marks a read cycle.
    input wire logic [ddrosc_pkg::CAL_W-1:0] dll_cal, // Delay calibration code.
    output logic read_strobe_shifted, // Delayed strobe for read capture.
    output logic write_strobe_shifted, // Delayed strobe for write mux.
    output logic sync_clock_polarity, // Edge choice for read synchronisers.
    output logic read_word_valid, // One pulse per captured read pair.
    output logic sys_clk_level // System clock phase in use.
);
    import ddrosc_pkg::*;

    typedef struct packed {
        logic phase;
        logic [DATA_LANES-1:0] rise_hold_reg;
        logic [DATA_LANES-1:0] second_cap;
        logic [DATA_LANES-1:0] fall_hold_reg;
        logic [DATA_LANES-1:0] sdr_q;
        logic [DATA_LANES-1:0] pad;
        logic oe;
        logic s1;
        logic s2;
        logic s3;
        logic strobe_lvl;
        logic [CAL_W-1:0] rd_cnt;
        logic rd_target;
        logic rstrobe;
        logic [CAL_W-1:0] wr_cnt;
        logic wr_target;
        logic wstrobe;
        ddrosc_rd_state_t rd_state;
        logic pol;
        logic valid;
    } ddrosc_st_t;

    ddrosc_st_t st;
    ddrosc_st_t next_st;
    logic fifo_valid;
    logic fifo_pop;
    logic [WORD_W-1:0] fifo_word;
    logic [DATA_LANES-1:0] head_first;
    logic [DATA_LANES-1:0] head_second;
    logic rise_ev;
    logic strobe_change;
    logic strobe_rise;
    logic mem_mode;

    // Delay load for a shifted strobe; never below one cycle.
    function automatic logic [CAL_W-1:0] delay_load(input logic [CAL_W-1:0] code, input int shift);
        logic [CAL_W-1:0] d;
        d = code >> shift;
        if (d == CNT_RESET)
        begin
            d = 6'h01;
        end
        return d;
    endfunction : delay_load

    // Core words pass through the buffer; a word is drained at each system rise while the pads are enabled.
    ddrosc_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .in_data({second_data_in, first_data_in}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_word)
    );

    assign head_first = fifo_word[FIRST_LSB +: DATA_LANES];
    assign head_second = fifo_word[SECOND_LSB +: DATA_LANES];
    // The system clock is core_clk divided by two; a rise happens when phase is low.
    assign rise_ev = !st.phase;
    assign fifo_pop = rise_ev && st.oe;
    // A strobe change counts only once the second and third stages agree.
    assign strobe_change = (st.s2 == st.s3) && (st.s3 != st.strobe_lvl);
    assign strobe_rise = strobe_change && st.s3;
    // Without the right-edge logic memory mode behaves as generic double rate.
    assign mem_mode = RIGHT_EDGE && (mode == MODE_MDDR); // RULE_04

    always_comb
    begin
        next_st = st;
        next_st.valid = 1'b0;
        next_st.phase = !st.phase;
        next_st.oe = out_enable;

        if (rise_ev && fifo_valid && st.oe)
        begin
            next_st.rise_hold_reg = head_first; // RULE_02
            next_st.second_cap = head_second; // RULE_05
        end
        if (!rise_ev)
        begin
            next_st.fall_hold_reg = st.second_cap; // RULE_02
        end

        // Register form samples at the rise; latch form stays open while the clock is high.
        if (sdr_latch)
        begin
            if (next_st.phase && fifo_valid)
            begin
                next_st.sdr_q = head_first; // RULE_01
            end
        end
        else if (rise_ev && fifo_valid && st.oe)
        begin
            next_st.sdr_q = head_first; // RULE_01
        end

        case (mode)
            MODE_SDR: next_st.pad = st.sdr_q; // RULE_01
            default:
            begin
                if (mem_mode ? st.wstrobe : next_st.phase) // RULE_03 RULE_06
                begin
                    next_st.pad = st.rise_hold_reg; // RULE_15
                end
                else
                begin
                    next_st.pad = st.fall_hold_reg; // RULE_15
                end
            end
        endcase

        // Three-stage synchroniser for the strobe pin.
        next_st.s1 = strobe_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (strobe_change)
        begin
            next_st.strobe_lvl = st.s3;
        end

        // Shifted strobes follow the strobe after the calibrated delay.
        if (strobe_change)
        begin
            next_st.rd_cnt = delay_load(dll_cal, 0); // RULE_14
            next_st.rd_target = st.s3;
            next_st.wr_cnt = delay_load(dll_cal, WR_DELAY_SHIFT); // RULE_14
            next_st.wr_target = st.s3;
        end
        else
        begin
            if (st.rd_cnt != CNT_RESET)
            begin
                next_st.rd_cnt = st.rd_cnt - 1'b1;
            end
            if (st.wr_cnt != CNT_RESET)
            begin
                next_st.wr_cnt = st.wr_cnt - 1'b1;
            end
        end
        if (st.rd_cnt == 6'h01)
        begin
            next_st.rstrobe = st.rd_target; // RULE_09
            // A pair is complete on each falling shifted read strobe while the read is active.
            next_st.valid = (st.rd_state == RD_ACT) && st.rstrobe && !st.rd_target; // RULE_08
        end
        if (st.wr_cnt == 6'h01)
        begin
            next_st.wstrobe = st.wr_target; // RULE_09
        end

        case (st.rd_state)
            RD_IDLE:
            begin
                // Strobe seen low during a read marks the preamble.
                if (read_en && !st.strobe_lvl)
                begin
                    next_st.rd_state = RD_PRE; // RULE_11
                end
            end
            RD_PRE:
            begin
                if (!read_en)
                begin
                    next_st.rd_state = RD_IDLE;
                end
                else if (strobe_rise)
                begin
                    next_st.pol = st.phase; // RULE_10 RULE_12
                    next_st.rd_state = RD_ACT;
                end
            end
            RD_ACT:
            begin
                if (!read_en)
                begin
                    next_st.rd_state = RD_IDLE; // RULE_11
                end
            end
            default: next_st.rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.rd_state <= RD_IDLE;
            // The strobe pin idles at its termination level. Starting the synchroniser,
            // the edge detector and the shifted strobes there keeps a false edge from
            // following reset and leaves the write mux on the rise register when idle.
            st.s1 <= STROBE_IDLE;
            st.s2 <= STROBE_IDLE;
            st.s3 <= STROBE_IDLE;
            st.strobe_lvl <= STROBE_IDLE;
            st.rd_target <= STROBE_IDLE;
            st.wr_target <= STROBE_IDLE;
            st.rstrobe <= STROBE_IDLE;
            st.wstrobe <= STROBE_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pad_out = st.pad;
    assign pad_oe = st.oe;
    assign read_strobe_shifted = st.rstrobe;
    assign write_strobe_shifted = st.wstrobe;
    assign sync_clock_polarity = st.pol;
    assign read_word_valid = st.valid;
    assign sys_clk_level = st.phase;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_rise_take;
        rise_ev && fifo_valid && st.oe;
    endsequence

    sequence s_preamble_rise;
        (st.rd_state == RD_PRE) && read_en && strobe_rise;
    endsequence

    a_rise_capture: assert property (s_rise_take |=> st.rise_hold_reg == $past(head_first)) // RULE_02
        else $error("Rise register missed the first bits.");
    a_fall_transfer: assert property (s_rise_take ##1 1'b1 |=> st.fall_hold_reg == $past(head_second, 2)) // RULE_05
        else $error("Fall register did not take the second bits.");
    a_generic_mux_high: assert property ((mode == MODE_GDDR && !st.phase) |=> pad_out == $past(st.rise_hold_reg)) // RULE_15
        else $error("High system clock did not drive the rise register.");
    a_generic_mux_low: assert property ((mode == MODE_GDDR && st.phase) |=> pad_out == $past(st.fall_hold_reg)) // RULE_03
        else $error("Low system clock did not drive the fall register.");
    a_mem_mux_strobe: assert property ((mem_mode && !st.wstrobe) |=> pad_out == $past(st.fall_hold_reg)) // RULE_06
        else $error("Memory mode mux ignored the write strobe.");
    a_sdr_register: assert property ((mode == MODE_SDR && !sdr_latch) ##0 s_rise_take ##1 1'b1
        |=> pad_out == $past(head_first, 2)) // RULE_01
        else $error("Single-rate path lost the first bits.");
    a_cal_delay_load: assert property (strobe_change |=> st.rd_cnt == delay_load($past(dll_cal), 0)) // RULE_14
        else $error("Read delay not loaded from calibration.");
    a_strobe_follow: assert property ((strobe_change && dll_cal == 6'h02) ##1 !strobe_change
        |=> ##1 read_strobe_shifted == $past(st.rd_target)) // RULE_09
        else $error("Read shifted strobe did not follow the strobe.");
    a_polarity_set: assert property (s_preamble_rise |=> sync_clock_polarity == $past(st.phase)
        && st.rd_state == RD_ACT) // RULE_12
        else $error("Polarity not taken at the first strobe rise.");
    a_read_restart: assert property ((st.rd_state == RD_ACT && !read_en) |=> st.rd_state == RD_IDLE
        ##1 (read_en && !st.strobe_lvl) [*1] |=> st.rd_state == RD_PRE) // RULE_11
        else $error("Read cycle did not restart polarity evaluation.");
endmodule : ddrosc_top
`default_nettype wire
